// file: rtl/ssp_pkg.sv
package ssp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Word and target select
  localparam int SSP_WORD_W    = 32;
  localparam int SSP_SEL_W     = 3;
  localparam int SSP_NUM_LATCH = 6;

  localparam logic [2:0] SSP_SEL_R0 = 3'h0;
  localparam logic [2:0] SSP_SEL_R1 = 3'h1;
  localparam logic [2:0] SSP_SEL_R2 = 3'h2;
  localparam logic [2:0] SSP_SEL_R4 = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Field layout
  localparam int SSP_INT_LSB   = 15;
  localparam int SSP_INT_W     = 16;
  localparam int SSP_FRACTION_NUMERATOR_LSB  = 3;
  localparam int SSP_FRACTION_NUMERATOR_W    = 12;
  localparam int SSP_PHASE_LSB = 15;
  localparam int SSP_PHASE_W   = 12;
  localparam int SSP_MOD_LSB   = 3;
  localparam int SSP_MOD_W     = 12;
  localparam int SSP_PRESC_BIT = 27;
  localparam int SSP_MON_LSB   = 26;
  localparam int SSP_MON_W     = 3;
  localparam int SSP_DBL_BIT   = 25;
  localparam int SSP_HALF_BIT  = 24;
  localparam int SSP_RCNT_LSB  = 14;
  localparam int SSP_RCNT_W    = 10;
  localparam int SSP_BUFEN_BIT = 13;
  localparam int SSP_CP_LSB    = 9;
  localparam int SSP_CP_W      = 3;
  localparam int SSP_PDN_BIT   = 5;
  localparam int SSP_CPTRI_BIT = 4;
  localparam int SSP_CRST_BIT  = 3;
  localparam int SSP_FBSEL_BIT = 23;
  localparam int SSP_DIV_LSB   = 20;
  localparam int SSP_DIV_W     = 3;
  localparam int SSP_MUTE_UNTIL_LOCKED_BIT  = 10;
  localparam int SSP_RFEN_BIT  = 5;
  localparam int SSP_PWR_LSB   = 3;
  localparam int SSP_PWR_W     = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Monitor select codes
  localparam logic [2:0] SSP_MON_TRI   = 3'h0;
  localparam logic [2:0] SSP_MON_HIGH  = 3'h1;
  localparam logic [2:0] SSP_MON_LOW   = 3'h2;
  localparam logic [2:0] SSP_MON_RDIV  = 3'h3;
  localparam logic [2:0] SSP_MON_NDIV  = 3'h4;
  localparam logic [2:0] SSP_MON_ALOCK = 3'h5;
  localparam logic [2:0] SSP_MON_DLOCK = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser lanes
  localparam int SSP_SYNC_W    = 5;
  localparam int SSP_SI_STROBE = 0;
  localparam int SSP_SI_DLOCK  = 1;
  localparam int SSP_SI_ALOCK  = 2;
  localparam int SSP_SI_REF    = 3;
  localparam int SSP_SI_FB     = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int SSP_CLK_PS = 8000;
  localparam int SSP_ABL_PS = 4200;
  localparam int SSP_ABL_RAW = (SSP_ABL_PS + SSP_CLK_PS - 1) / SSP_CLK_PS;
  localparam int SSP_ABL_CYC = (SSP_ABL_RAW < 1) ? 1 : SSP_ABL_RAW;

  ////////////////////////////////////////////////////////////////////////////
  // Active synthesizer settings
  typedef struct packed {
    logic [SSP_INT_W-1:0]   int_value;
    logic [SSP_FRACTION_NUMERATOR_W-1:0]  fraction_numerator;
    logic [SSP_MOD_W-1:0]   fraction_modulus;
    logic [SSP_PHASE_W-1:0] phase_value;
    logic [SSP_RCNT_W-1:0]  ref_count;
    logic                   ref_double;
    logic                   reference_halving_bit;
    logic [SSP_CP_W-1:0]    cp_current;
    logic [SSP_DIV_W-1:0]   out_div_sel;
  } ssp_cfg_t;

  localparam ssp_cfg_t SSP_CFG_RST = '0;

endpackage : ssp_pkg

// file: rtl/ssp_serial_shift.sv
`timescale 1ns/100ps
module ssp_serial_shift
  import ssp_pkg::*;
(
  input  wire logic                  sclk,
  input  wire logic                  rstn,
  input  wire logic                  sdata,
  output logic      [SSP_WORD_W-1:0] shift_word
);

  logic rst_meta_ff;
  logic link_rstn_ff;

  // Reset brought into the serial clock domain
  always_ff @(posedge sclk) begin
    rst_meta_ff  <= rstn;
    link_rstn_ff <= rst_meta_ff;
  end

  always_ff @(posedge sclk) begin
    if (!link_rstn_ff) begin
      shift_word <= '0;
    end else begin
      shift_word <= {shift_word[SSP_WORD_W-2:0], sdata};
    end
  end

  AST_SHIFT_IN: assert property (@(posedge sclk) disable iff (!rstn || !link_rstn_ff)
    1'b1 |=> (shift_word[0] == $past(sdata)) &&
             (shift_word[SSP_WORD_W-1:1] == $past(shift_word[SSP_WORD_W-2:0])))
    else $error("serial word did not shift msb first");

endmodule : ssp_serial_shift

// file: rtl/ssp_phase_detect.sv
`timescale 1ns/100ps
module ssp_phase_detect
  import ssp_pkg::*;
#(
  parameter int ABL_CYC = SSP_ABL_CYC
)(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic ref_edge,
  input  wire logic fb_edge,
  output logic      pd_up,
  output logic      pd_down
);

  localparam int CNT_W = $clog2(ABL_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ABL_CYC - 1);

  logic [CNT_W-1:0] abl_cnt_ff;

  always_ff @(posedge clk) begin
    if (!rstn || (ce && !enable)) begin
      pd_up      <= 1'b0;
      pd_down    <= 1'b0;
      abl_cnt_ff <= '0;
    end else if (ce) begin
      if (pd_up && pd_down) begin
        if (abl_cnt_ff == CNT_LAST) begin
          pd_up      <= 1'b0;
          pd_down    <= 1'b0;
          abl_cnt_ff <= '0;
        end else begin
          abl_cnt_ff <= abl_cnt_ff + CNT_W'(1);
        end
      end else begin
        if (ref_edge) begin
          pd_up <= 1'b1;
        end
        if (fb_edge) begin
          pd_down <= 1'b1;
        end
      end
    end
  end

  AST_ABL_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    (ce && enable && pd_up && pd_down && abl_cnt_ff == CNT_LAST) |=> (!pd_up && !pd_down))
    else $error("anti-backlash reset did not end on time");

endmodule : ssp_phase_detect

// file: rtl/ssp_program_latches.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Each serial clock rising edge shifts one data bit into a 32-bit register.
// - Words go in most significant bit first; bit 0 arrives last.
// - Latch strobe rising edge copies the whole shifted word into one latch.
// - Bits 2 to 0 of the word choose the destination latch.
// - Codes 0 to 5 pick latches 0 to 5; codes 6 and 7 are ignored.
// - Phase, modulus, doubler, halving, reference count, pump current wait pending.
// - Pending values go live only when latch zero is next written.
// - Output divider select waits for latch zero only when buffer enable is set.
// - Latch four bits 4 to 3 pick one of four output power steps.
// - Mute-until-locked keeps output stage supply off until digital lock.
// - Monitor select bits 28 to 26 of latch two choose the monitor pin source.
// - Holds 10-bit reference count, 16-bit integer, 12-bit fraction and modulus.
// - Phase detector reset pulse lasts a fixed 4.2 ns, rounded up to cycles.
// - Latch zero bits 30 to 15 hold the 16-bit integer divide value.
// - Lock indicator is high while locked and low once lock is lost.
module ssp_program_latches
  import ssp_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire logic                 sclk,
  input  wire logic                 sdata,
  input  wire logic                 latch_strobe,
  input  wire logic                 dig_lock_in,
  input  wire logic                 ana_lock_in,
  input  wire logic                 ref_div_in,
  input  wire logic                 fb_div_in,
  output ssp_cfg_t                  cfg_active,
  output logic                      prescaler_sel,
  output logic                      fb_select,
  output logic                      power_down,
  output logic                      cp_tristate,
  output logic                      counter_reset,
  output logic      [SSP_PWR_W-1:0] output_power,
  output logic                      rf_supply_en,
  output logic                      lock_indicator,
  output logic                      monitor_output_pin,
  output logic      [SSP_WORD_W-1:0] latch3_word,
  output logic      [SSP_WORD_W-1:0] latch5_word,
  output logic                      pd_up,
  output logic                      pd_down
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [SSP_WORD_W-1:0] shift_word;
  logic [SSP_SYNC_W-1:0] meta_ff;
  logic [SSP_SYNC_W-1:0] sync_ff;
  logic [SSP_SYNC_W-1:0] prev_ff;
  logic [SSP_SYNC_W-1:0] pin_in;
  logic [SSP_WORD_W-1:0] latch_ff [SSP_NUM_LATCH];
  logic [SSP_SEL_W-1:0]  target_select_bits;
  logic                  load;
  logic                  load_r0;
  logic                  load_r4;
  logic                  buf_en;
  logic [SSP_MON_W-1:0]  monitor_select_bits;
  logic                  mute_until_locked;
  logic                  rf_out_enable;
  logic                  ref_edge;
  logic                  fb_edge;
  logic                  pd_enable;
  ssp_cfg_t              cfg_ff;
  logic                  rf_supply_en_ff;
  logic                  lock_indicator_ff;
  logic                  monitor_ff;
  logic                  nxt_monitor;

  ////////////////////////////////////////////////////////////////////////////
  // Serial link side
  ssp_serial_shift u_shift (
    .sclk       (sclk),
    .rstn       (rstn),
    .sdata      (sdata),
    .shift_word (shift_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign pin_in[SSP_SI_STROBE] = latch_strobe;
  assign pin_in[SSP_SI_DLOCK]  = dig_lock_in;
  assign pin_in[SSP_SI_ALOCK]  = ana_lock_in;
  assign pin_in[SSP_SI_REF]    = ref_div_in;
  assign pin_in[SSP_SI_FB]     = fb_div_in;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else if (ce) begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // The strobe is high only after the host stopped clocking, so the
  // shifted word is static while it is sampled here.
  // strobe rising edge
  assign load               = ce && sync_ff[SSP_SI_STROBE] && !prev_ff[SSP_SI_STROBE];
  assign target_select_bits = shift_word[SSP_SEL_W-1:0];
  assign load_r0            = load && (target_select_bits == SSP_SEL_R0);
  assign load_r4            = load && (target_select_bits == SSP_SEL_R4);

  ////////////////////////////////////////////////////////////////////////////
  // Latch bank
  for (genvar i = 0; i < SSP_NUM_LATCH; i++) begin : g_latch
    always_ff @(posedge clk) begin
      if (!rstn) begin
        latch_ff[i] <= '0;
      end else if (load && (target_select_bits == SSP_SEL_W'(i))) begin
        latch_ff[i] <= shift_word;
      end
    end
  end

  assign buf_en              = latch_ff[SSP_SEL_R2][SSP_BUFEN_BIT];
  assign monitor_select_bits = latch_ff[SSP_SEL_R2][SSP_MON_LSB +: SSP_MON_W];
  assign mute_until_locked   = latch_ff[SSP_SEL_R4][SSP_MUTE_UNTIL_LOCKED_BIT];
  assign rf_out_enable       = latch_ff[SSP_SEL_R4][SSP_RFEN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Active settings
  // counter values
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_ff <= SSP_CFG_RST;
    end else if (load_r0) begin
      cfg_ff.int_value             <= shift_word[SSP_INT_LSB +: SSP_INT_W];
      cfg_ff.fraction_numerator    <= shift_word[SSP_FRACTION_NUMERATOR_LSB +: SSP_FRACTION_NUMERATOR_W];
      cfg_ff.fraction_modulus      <= latch_ff[SSP_SEL_R1][SSP_MOD_LSB +: SSP_MOD_W];
      cfg_ff.phase_value           <= latch_ff[SSP_SEL_R1][SSP_PHASE_LSB +: SSP_PHASE_W];
      cfg_ff.ref_count             <= latch_ff[SSP_SEL_R2][SSP_RCNT_LSB +: SSP_RCNT_W];
      cfg_ff.ref_double            <= latch_ff[SSP_SEL_R2][SSP_DBL_BIT];
      cfg_ff.reference_halving_bit <= latch_ff[SSP_SEL_R2][SSP_HALF_BIT];
      cfg_ff.cp_current            <= latch_ff[SSP_SEL_R2][SSP_CP_LSB +: SSP_CP_W];
      cfg_ff.out_div_sel           <= latch_ff[SSP_SEL_R4][SSP_DIV_LSB +: SSP_DIV_W];
    end else if (load_r4 && !buf_en) begin
      cfg_ff.out_div_sel <= shift_word[SSP_DIV_LSB +: SSP_DIV_W];
    end
  end

  assign cfg_active    = cfg_ff;
  assign prescaler_sel = latch_ff[SSP_SEL_R1][SSP_PRESC_BIT];
  assign fb_select     = latch_ff[SSP_SEL_R4][SSP_FBSEL_BIT];
  assign power_down    = latch_ff[SSP_SEL_R2][SSP_PDN_BIT];
  assign cp_tristate   = latch_ff[SSP_SEL_R2][SSP_CPTRI_BIT];
  assign counter_reset = latch_ff[SSP_SEL_R2][SSP_CRST_BIT];
  assign output_power  = latch_ff[SSP_SEL_R4][SSP_PWR_LSB +: SSP_PWR_W];
  assign latch3_word   = latch_ff[3];
  assign latch5_word   = latch_ff[5];

  ////////////////////////////////////////////////////////////////////////////
  // Lock, mute and monitor
  // lock follows detector
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lock_indicator_ff <= 1'b0;
    end else if (ce) begin
      lock_indicator_ff <= sync_ff[SSP_SI_DLOCK];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rf_supply_en_ff <= 1'b0;
    end else if (ce) begin
      rf_supply_en_ff <= rf_out_enable && !power_down &&
                         (!mute_until_locked || sync_ff[SSP_SI_DLOCK]);
    end
  end

  always_comb begin
    case (monitor_select_bits)
      SSP_MON_TRI:   nxt_monitor = 1'b0;
      SSP_MON_HIGH:  nxt_monitor = 1'b1;
      SSP_MON_LOW:   nxt_monitor = 1'b0;
      SSP_MON_RDIV:  nxt_monitor = sync_ff[SSP_SI_REF];
      SSP_MON_NDIV:  nxt_monitor = sync_ff[SSP_SI_FB];
      SSP_MON_ALOCK: nxt_monitor = sync_ff[SSP_SI_ALOCK];
      SSP_MON_DLOCK: nxt_monitor = sync_ff[SSP_SI_DLOCK];
      default:       nxt_monitor = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      monitor_ff <= 1'b0;
    end else if (ce) begin
      monitor_ff <= nxt_monitor;
    end
  end

  assign lock_indicator     = lock_indicator_ff;
  assign rf_supply_en       = rf_supply_en_ff;
  assign monitor_output_pin = monitor_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Phase detector
  assign ref_edge  = sync_ff[SSP_SI_REF] && !prev_ff[SSP_SI_REF];
  assign fb_edge   = sync_ff[SSP_SI_FB] && !prev_ff[SSP_SI_FB];
  assign pd_enable = !power_down && !counter_reset;

  ssp_phase_detect u_pd (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .enable   (pd_enable),
    .ref_edge (ref_edge),
    .fb_edge  (fb_edge),
    .pd_up    (pd_up),
    .pd_down  (pd_down)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // whole word copied
  AST_LATCH_COPY: assert property (@(posedge clk) disable iff (!rstn)
    (load && target_select_bits == SSP_SEL_R2) |=> (latch_ff[SSP_SEL_R2] == $past(shift_word)))
    else $error("latch two did not take the shifted word");

  AST_NO_TARGET: assert property (@(posedge clk) disable iff (!rstn)
    (load && target_select_bits > 3'h5) |=>
      ($stable(latch_ff[0]) && $stable(latch_ff[1]) && $stable(latch_ff[2]) &&
       $stable(latch_ff[3]) && $stable(latch_ff[4]) && $stable(latch_ff[5])))
    else $error("unused target code changed a latch");

  AST_PEND_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    (load && target_select_bits == SSP_SEL_R1) |=> $stable(cfg_ff))
    else $error("double buffered value went live without latch zero");

  AST_R0_COMMIT: assert property (@(posedge clk) disable iff (!rstn)
    load_r0 |=> (cfg_ff.fraction_modulus == $past(latch_ff[SSP_SEL_R1][SSP_MOD_LSB +: SSP_MOD_W])) &&
                (cfg_ff.ref_count == $past(latch_ff[SSP_SEL_R2][SSP_RCNT_LSB +: SSP_RCNT_W])))
    else $error("pending values not committed by latch zero");

  AST_DIV_IMM: assert property (@(posedge clk) disable iff (!rstn)
    (load_r4 && !buf_en) |=> (cfg_ff.out_div_sel == $past(shift_word[SSP_DIV_LSB +: SSP_DIV_W])))
    else $error("divider select not applied at once");

  AST_DIV_BUF: assert property (@(posedge clk) disable iff (!rstn)
    (load_r4 && buf_en) |=> $stable(cfg_ff.out_div_sel))
    else $error("buffered divider select applied early");

  AST_INT_FIELD: assert property (@(posedge clk) disable iff (!rstn)
    load_r0 |=> (cfg_ff.int_value == $past(shift_word[SSP_INT_LSB +: SSP_INT_W])))
    else $error("integer value taken from wrong bits");

  AST_MUTE: assert property (@(posedge clk) disable iff (!rstn)
    (ce && mute_until_locked && !sync_ff[SSP_SI_DLOCK]) |=> !rf_supply_en)
    else $error("output stage powered before lock");

  AST_LOCK: assert property (@(posedge clk) disable iff (!rstn)
    (ce && $fell(sync_ff[SSP_SI_DLOCK])) |=> !lock_indicator)
    else $error("lock indicator stayed high after lock loss");

  AST_MON: assert property (@(posedge clk) disable iff (!rstn)
    (ce && monitor_select_bits == SSP_MON_DLOCK) |=> (monitor_output_pin == $past(sync_ff[SSP_SI_DLOCK])))
    else $error("monitor pin not showing digital lock");

  AST_POWER: assert property (@(posedge clk) disable iff (!rstn)
    (load_r4) |=> (output_power == $past(shift_word[SSP_PWR_LSB +: SSP_PWR_W])))
    else $error("output power step not taken from bits 4 to 3");

  AST_R4_COPY: assert property (@(posedge clk) disable iff (!rstn)
    load_r4 |=> (latch_ff[SSP_SEL_R4] == $past(shift_word)))
    else $error("latch four did not take the shifted word");

  AST_PEND_R2: assert property (@(posedge clk) disable iff (!rstn)
    (load && target_select_bits == SSP_SEL_R2) |=> $stable(cfg_ff))
    else $error("latch two value went live without latch zero");

  AST_LOCK_RISE: assert property (@(posedge clk) disable iff (!rstn)
    (ce && $rose(sync_ff[SSP_SI_DLOCK])) |=> lock_indicator)
    else $error("lock indicator stayed low after lock");

  AST_UNMUTE: assert property (@(posedge clk) disable iff (!rstn)
    (ce && rf_out_enable && !power_down && sync_ff[SSP_SI_DLOCK]) |=> rf_supply_en)
    else $error("output stage not powered after lock");

endmodule : ssp_program_latches

// file: tb/ssp_host_model.sv
`timescale 1ns/100ps
module ssp_host_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      sdata,
  output logic      latch_strobe
);
  initial begin
    sclk         = 1'b0;
    sdata        = 1'b0;
    latch_strobe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock runs only while bits go out; data flips once released
  task automatic pulse(input logic [31:0] w, input int n);
    #3;
    for (int i = n - 1; i >= 0; i--) begin
      sdata = w[i];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    sdata = ~sdata;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  // Whole word, then strobe with the serial clock held still
  task automatic send(input logic [31:0] w);
    pulse(w, 32);
    @(posedge clk);
    #1 latch_strobe = 1'b1;
    repeat (6) @(posedge clk);
    #1 latch_strobe = 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask : send
endmodule : ssp_host_model

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
  import ssp_pkg::*;
  typedef struct {logic snd; logic [31:0] w; int k; logic [31:0] e;} ssp_row_t;
  logic            clk, rstn, ce, sclk, sdata, latch_strobe;
  logic            dig_lock_in, ana_lock_in, ref_div_in, fb_div_in;
  ssp_cfg_t        cfg_active;
  logic            prescaler_sel, fb_select, power_down, cp_tristate, counter_reset;
  logic [1:0]      output_power;
  logic            rf_supply_en, lock_indicator, monitor_output_pin, pd_up, pd_down;
  logic [31:0]     latch3_word, latch5_word;
  int              err_count = 0;
  int              checked = 0;
  ssp_row_t        rows[$];

  ssp_host_model u_host (.clk(clk), .sclk(sclk), .sdata(sdata), .latch_strobe(latch_strobe));

  ssp_program_latches u_dut (
    .clk(clk), .rstn(rstn), .ce(ce), .sclk(sclk), .sdata(sdata), .latch_strobe(latch_strobe),
    .dig_lock_in(dig_lock_in), .ana_lock_in(ana_lock_in), .ref_div_in(ref_div_in),
    .fb_div_in(fb_div_in), .cfg_active(cfg_active), .prescaler_sel(prescaler_sel),
    .fb_select(fb_select), .power_down(power_down), .cp_tristate(cp_tristate),
    .counter_reset(counter_reset), .output_power(output_power), .rf_supply_en(rf_supply_en),
    .lock_indicator(lock_indicator), .monitor_output_pin(monitor_output_pin),
    .latch3_word(latch3_word), .latch5_word(latch5_word), .pd_up(pd_up), .pd_down(pd_down)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] w0(logic [15:0] n, logic [11:0] f);
    return {1'b0, n, f, 3'h0};
  endfunction : w0
  function automatic logic [31:0] w1(logic p, logic [11:0] ph, logic [11:0] m);
    return {4'h0, p, ph, m, 3'h1};
  endfunction : w1
  function automatic logic [31:0] w2(logic [2:0] mo, logic [1:0] dh, logic [9:0] rc, logic be,
                                     logic [2:0] cp, logic [2:0] pt);
    return {3'h0, mo, dh, rc, be, 1'b0, cp, 3'h0, pt, 3'h2};
  endfunction : w2
  function automatic logic [31:0] w4(logic fb, logic [2:0] dv, logic mu, logic [2:0] ep);
    return {8'h0, fb, dv, 9'h0, mu, 4'h0, ep, 3'h4};
  endfunction : w4

  function automatic logic [31:0] obs(int k);
    case (k)
      0:       obs = latch3_word;
      1:       obs = latch5_word;
      2:       obs = 32'(cfg_active.int_value);
      3:       obs = 32'(cfg_active.fraction_numerator);
      4:       obs = 32'(cfg_active.fraction_modulus);
      5:       obs = 32'(cfg_active.phase_value);
      6:       obs = 32'(cfg_active.ref_count);
      7:       obs = 32'({cfg_active.ref_double, cfg_active.reference_halving_bit});
      8:       obs = 32'(cfg_active.cp_current);
      9:       obs = 32'(cfg_active.out_div_sel);
      10:      obs = 32'({prescaler_sel, fb_select, power_down, cp_tristate, counter_reset});
      11:      obs = 32'(output_power);
      12:      obs = 32'(monitor_output_pin);
      default: obs = 32'(rf_supply_en);
    endcase
  endfunction : obs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  task automatic rst_chk();
    rstn = 1'b0;
    // Serial side needs clock edges while reset is low
    u_host.pulse(32'h0, 3);
    wt(4);
    check(32'({|cfg_active, prescaler_sel, fb_select, power_down, cp_tristate, counter_reset,
               output_power, rf_supply_en, lock_indicator, monitor_output_pin, pd_up, pd_down,
               |latch3_word, |latch5_word}), 32'h0);
    rstn = 1'b1;
    u_host.pulse(32'h5, 3);
  endtask : rst_chk

  task automatic conclude();
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  initial begin
    #600000;
    err_count++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn        = 1'b0;
    ce          = 1'b1;
    dig_lock_in = 1'b0;
    ana_lock_in = 1'b1;
    ref_div_in  = 1'b0;
    fb_div_in   = 1'b0;
    rows = '{'{1, w0(16'h1234, 12'h567), 2, 32'h1234}, '{0, 0, 3, 32'h567},
             '{1, w1(1'h1, 12'habc, 12'h0f3), 4, 32'h0}, '{0, 0, 5, 32'h0}, '{0, 0, 10, 32'h10},
             '{1, w2(3'h6, 2'h3, 10'h3ff, 1'h0, 3'h5, 3'h1), 6, 32'h0}, '{0, 0, 8, 32'h0},
             '{0, 0, 10, 32'h11}, '{1, w0(16'hffff, 12'h0), 4, 32'h0f3}, '{0, 0, 5, 32'habc},
             '{0, 0, 6, 32'h3ff}, '{0, 0, 7, 32'h3}, '{0, 0, 8, 32'h5}, '{0, 0, 2, 32'hffff},
             '{0, 0, 3, 32'h0}, '{1, w4(1'h1, 3'h3, 1'h0, 3'h6), 9, 32'h3}, '{0, 0, 11, 32'h2},
             '{0, 0, 10, 32'h19}, '{0, 0, 13, 32'h1},
             '{1, w4(1'h1, 3'h3, 1'h0, 3'h4), 11, 32'h0}, '{1, w4(1'h1, 3'h3, 1'h0, 3'h5), 11, 32'h1},
             '{1, w4(1'h1, 3'h3, 1'h0, 3'h7), 11, 32'h3}, '{1, w4(1'h1, 3'h3, 1'h0, 3'h6), 11, 32'h2},
             '{1, 32'hdeadbee3, 0, 32'hdeadbee3}, '{1, 32'h1234567d, 1, 32'h1234567d},
             '{1, 32'hfffffffe, 0, 32'hdeadbee3}, '{1, 32'hffffffff, 1, 32'h1234567d},
             '{0, 0, 2, 32'hffff},
             '{1, w2(3'h1, 2'h3, 10'h3ff, 1'h0, 3'h5, 3'h0), 12, 32'h1},
             '{1, w2(3'h2, 2'h3, 10'h3ff, 1'h0, 3'h5, 3'h0), 12, 32'h0},
             '{1, w2(3'h5, 2'h3, 10'h3ff, 1'h0, 3'h5, 3'h0), 12, 32'h1},
             '{1, w2(3'h0, 2'h3, 10'h3ff, 1'h0, 3'h5, 3'h0), 12, 32'h0},
             '{1, w2(3'h7, 2'h3, 10'h3ff, 1'h0, 3'h5, 3'h0), 12, 32'h0},
             '{1, w2(3'h3, 2'h3, 10'h3ff, 1'h0, 3'h5, 3'h0), 12, 32'h0},
             '{1, w2(3'h4, 2'h3, 10'h3ff, 1'h0, 3'h5, 3'h0), 12, 32'h0},
             '{1, w2(3'h6, 2'h3, 10'h3ff, 1'h0, 3'h5, 3'h0), 12, 32'h0}, '{0, 0, 10, 32'h18},
             '{1, w2(3'h1, 2'h3, 10'h3ff, 1'h0, 3'h5, 3'h4), 13, 32'h0}, '{0, 0, 10, 32'h1c},
             '{1, w2(3'h1, 2'h3, 10'h3ff, 1'h0, 3'h5, 3'h0), 13, 32'h1}};
    rst_chk();
    foreach (rows[i]) begin
      if (rows[i].snd)
        u_host.send(rows[i].w);
      check(obs(rows[i].k), rows[i].e);
    end
    // Divider waits for latch zero while buffering is on
    u_host.send(w2(3'h6, 2'h3, 10'h3ff, 1'h1, 3'h5, 3'h0));
    u_host.send(w4(1'h1, 3'h6, 1'h0, 3'h6));
    check(obs(9), 32'h3);
    u_host.send(w0(16'hffff, 12'h0));
    check(obs(9), 32'h6);
    // Output supply held off until lock
    u_host.send(w4(1'h1, 3'h6, 1'h1, 3'h6));
    check(obs(13), 32'h0);
    dig_lock_in = 1'b1;
    wt(6);
    check(obs(13), 32'h1);
    check(32'(lock_indicator), 32'h1);
    check(obs(12), 32'h1);
    dig_lock_in = 1'b0;
    wt(6);
    check(32'({lock_indicator, rf_supply_en}), 32'h0);
    // Clock enable low freezes the lock path
    ce          = 1'b0;
    dig_lock_in = 1'b1;
    wt(6);
    check(32'(lock_indicator), 32'h0);
    ce          = 1'b1;
    wt(6);
    check(32'(lock_indicator), 32'h1);
    dig_lock_in = 1'b0;
    wt(6);
    // Phase detector set then mutual clear, monitor on counter outputs
    u_host.send(w2(3'h3, 2'h3, 10'h3ff, 1'h1, 3'h5, 3'h0));
    ref_div_in = 1'b1;
    wt(6);
    check(32'({pd_up, pd_down}), 32'h2);
    check(obs(12), 32'h1);
    fb_div_in = 1'b1;
    wt(3);
    check(32'({pd_up, pd_down}), 32'h3);
    wt(1);
    check(32'({pd_up, pd_down}), 32'h0);
    u_host.send(w2(3'h4, 2'h3, 10'h3ff, 1'h1, 3'h5, 3'h0));
    check(obs(12), 32'h1);
    ref_div_in = 1'b0;
    fb_div_in  = 1'b0;
    wt(2);
    rst_chk();
    conclude();
  end
endmodule : tb
